//--- verilog/lsf_pkg.sv
// lsf_pkg: register map, field positions, reset values and timing for the
// line supervision and feed control block.
// assumes a single 25 MHz core clock and an 8-bit register port.
package lsf_pkg;

  // register offsets
  localparam logic [7:0] LSF_OFS_BATT_FEED   = 8'h42;
  localparam logic [7:0] LSF_OFS_AUTO_MAN    = 8'h43;
  localparam logic [7:0] LSF_OFS_DET_STATUS  = 8'h44;
  localparam logic [7:0] LSF_OFS_LC_DEBOUNCE = 8'h45;
  localparam logic [7:0] LSF_OFS_RT_DEBOUNCE = 8'h46;
  localparam logic [7:0] LSF_OFS_ILIM        = 8'h47;

  // writable bit masks; everything else is reserved and reads zero
  localparam logic [7:0] LSF_MASK_BATT_FEED  = 8'h19;
  localparam logic [7:0] LSF_MASK_AUTO_MAN   = 8'h7F;
  localparam logic [7:0] LSF_MASK_DEBOUNCE   = 8'h7F;
  localparam logic [7:0] LSF_MASK_ILIM       = 8'h07;

  // reset values
  localparam logic [7:0] LSF_RST_BATT_FEED   = 8'h00;
  localparam logic [7:0] LSF_RST_AUTO_MAN    = 8'h1F;
  localparam logic [7:0] LSF_RST_LC_DEBOUNCE = 8'h0A;
  localparam logic [7:0] LSF_RST_RT_DEBOUNCE = 8'h0A;
  localparam logic [7:0] LSF_RST_ILIM        = 8'h00;

  // battery feed control fields
  localparam int LSF_BIT_TRACK     = 0;
  localparam int LSF_BIT_FORCE_BATTERY_HIGH     = 3;
  localparam int LSF_BIT_OVR_RANGE = 4;

  // automatic / manual control fields
  localparam int LSF_BIT_AUTO_OPEN = 0;
  localparam int LSF_BIT_AUTO_LC   = 1;
  localparam int LSF_BIT_AUTO_RT   = 2;
  localparam int LSF_BIT_AUTO_BAT  = 3;
  localparam int LSF_BIT_SPEEDUP   = 4;
  localparam int LSF_BIT_DIFF_MAN  = 5;
  localparam int LSF_BIT_CM_MAN    = 6;

  // linefeed state encoding
  localparam logic [2:0] LSF_LF_OPEN      = 3'h0;
  localparam logic [2:0] LSF_LF_FWD_ACT   = 3'h1;
  localparam logic [2:0] LSF_LF_FWD_OHT   = 3'h2;
  localparam logic [2:0] LSF_LF_TIP_OPEN  = 3'h3;
  localparam logic [2:0] LSF_LF_RINGING   = 3'h4;
  localparam logic [2:0] LSF_LF_REV_ACT   = 3'h5;
  localparam logic [2:0] LSF_LF_REV_OHT   = 3'h6;
  localparam logic [2:0] LSF_LF_RING_OPEN = 3'h7;

  // loop current: base and step in mA
  localparam logic [5:0] LSF_ILIM_BASE_MA = 6'h14;
  localparam logic [5:0] LSF_ILIM_STEP_MA = 6'h03;

  // debounce step time and its length in core clock cycles (rounded up)
  localparam int LSF_CLK_PERIOD_PS = 40000;
  localparam int LSF_DEB_STEP_PS   = 1250000000;
  localparam int LSF_TICK_CYCLES   =
    (LSF_DEB_STEP_PS + LSF_CLK_PERIOD_PS - 1) / LSF_CLK_PERIOD_PS;

endpackage : lsf_pkg

//--- verilog/lsf_feed_ctrl.sv
// lsf_feed_ctrl: battery feed and auto/manual control registers, loop
// closure and ring trip debounce, linefeed shadow state and loop current code.
// assumes the comparator and alarm arrive asynchronously on pins and that the
// linefeed register and voltage settings live elsewhere on the same clock.
`timescale 1ns/1ps

module lsf_feed_ctrl
  import lsf_pkg::*;
#(
  parameter int TICK_CYCLES = LSF_TICK_CYCLES,
  parameter int TICK_W      = 15
) (
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  output logic            reg_rvalid_out,
  input  wire logic       detect_raw_n_in,
  input  wire logic       power_alarm_in,
  input  wire logic [2:0] linefeed_state_written_in,
  input  wire logic [5:0] high_battery_setting_in,
  input  wire logic [5:0] low_battery_setting_in,
  input  wire logic [5:0] common_mode_setting_in,
  input  wire logic [5:0] on_hook_voltage_setting_in,
  output logic      [2:0] linefeed_state_actual_out,
  output logic            overhead_range_sel_out,
  output logic            force_battery_high_out,
  output logic      [5:0] battery_target_out,
  output logic      [5:0] battery_floor_out,
  output logic            battery_track_ring_out,
  output logic            cm_force_tip_out,
  output logic            cm_force_ring_out,
  output logic      [5:0] cm_level_out,
  output logic            diff_force_out,
  output logic      [5:0] diff_level_out,
  output logic            speedup_enable_out,
  output logic            low_battery_select_out,
  output logic      [2:0] loop_current_code_out,
  output logic      [5:0] loop_current_ma_out,
  output logic            ring_trip_filtered_out,
  output logic            loop_closure_filtered_out
);

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  logic [7:0]        batt_feed_ff;
  logic [7:0]        auto_man_ff;
  logic [7:0]        lc_deb_ff;
  logic [7:0]        rt_deb_ff;
  logic [7:0]        ilim_ff;
  logic [7:0]        rdata_ff;
  logic              rvalid_ff;
  logic [7:0]        nxt_rdata;
  logic [1:0]        raw_sync_ff;
  logic [1:0]        alarm_sync_ff;
  logic              raw_prev_ff;
  logic              alarm_prev_ff;
  logic [TICK_W-1:0] tick_cnt_ff;
  logic              tick;
  logic [6:0]        deb_cnt_ff [2];
  logic [1:0]        filt_ff;
  logic [1:0]        filt_prev_ff;
  logic [6:0]        deb_int [2];
  logic [1:0]        chan_on;
  logic [2:0]        shadow_ff;
  logic [2:0]        written_prev_ff;
  logic [2:0]        nxt_shadow;
  logic              alarm_rise;
  logic              rt_rise;
  logic              lc_rise;
  logic [5:0]        batt_tgt_ff;
  logic [5:0]        batt_floor_ff;
  logic              cm_tip_ff;
  logic              cm_ring_ff;
  logic              low_bat_ff;
  logic [5:0]        ilim_ma_ff;
  logic [5:0]        nxt_batt_tgt;
  logic              fwd_state;
  logic              rev_state;

  // register writes; reserved positions are masked off
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      batt_feed_ff <= LSF_RST_BATT_FEED;
      auto_man_ff  <= LSF_RST_AUTO_MAN;
      lc_deb_ff    <= LSF_RST_LC_DEBOUNCE;
      rt_deb_ff    <= LSF_RST_RT_DEBOUNCE;
      ilim_ff      <= LSF_RST_ILIM;
    end
    else if (reg_wr_in)
    begin
      case (reg_addr_in)
        LSF_OFS_BATT_FEED:   batt_feed_ff <= reg_wdata_in & LSF_MASK_BATT_FEED;
        LSF_OFS_AUTO_MAN:    auto_man_ff  <= reg_wdata_in & LSF_MASK_AUTO_MAN;
        LSF_OFS_LC_DEBOUNCE: lc_deb_ff    <= reg_wdata_in & LSF_MASK_DEBOUNCE;
        LSF_OFS_RT_DEBOUNCE: rt_deb_ff    <= reg_wdata_in & LSF_MASK_DEBOUNCE;
        LSF_OFS_ILIM:        ilim_ff      <= reg_wdata_in & LSF_MASK_ILIM;
        default:             ;
      endcase
    end
  end

  // read mux; status shows raw (active low) and both filtered bits
  always_comb
  begin
    case (reg_addr_in)
      LSF_OFS_BATT_FEED:   nxt_rdata = batt_feed_ff;
      LSF_OFS_AUTO_MAN:    nxt_rdata = auto_man_ff;
      LSF_OFS_DET_STATUS:  nxt_rdata = {5'h00, raw_sync_ff[1], filt_ff[1], filt_ff[0]};
      LSF_OFS_LC_DEBOUNCE: nxt_rdata = lc_deb_ff;
      LSF_OFS_RT_DEBOUNCE: nxt_rdata = rt_deb_ff;
      LSF_OFS_ILIM:        nxt_rdata = ilim_ff;
      default:             nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= reg_rd_in;
      if (reg_rd_in)
        rdata_ff <= nxt_rdata;
    end
  end

  // two flops before anything reads the comparator or the alarm pin
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      raw_sync_ff   <= 2'h3;
      alarm_sync_ff <= 2'h0;
      raw_prev_ff   <= 1'b1;
      alarm_prev_ff <= 1'b0;
    end
    else
    begin
      raw_sync_ff   <= {raw_sync_ff[0], detect_raw_n_in};
      alarm_sync_ff <= {alarm_sync_ff[0], power_alarm_in};
      raw_prev_ff   <= raw_sync_ff[1];
      alarm_prev_ff <= alarm_sync_ff[1];
    end
  end

  // shared 1.25 ms step tick for both filters
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in || tick)
      tick_cnt_ff <= '0;
    else
      tick_cnt_ff <= tick_cnt_ff + TICK_W'(1);
  end

  assign tick = (tick_cnt_ff == TICK_LAST);

  // one comparator feeds both filters: ring trip while ringing, loop closure
  // otherwise, so only the channel that fits the line state is counting
  assign deb_int[0] = lc_deb_ff[6:0];
  assign deb_int[1] = rt_deb_ff[6:0];
  assign chan_on[0] = (shadow_ff != LSF_LF_RINGING);
  assign chan_on[1] = (shadow_ff == LSF_LF_RINGING);

  // index 0 is loop closure, index 1 is ring trip
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_deb
    always_ff @(posedge clk_in)
    begin
      if (!rstn_in)
      begin
        deb_cnt_ff[ch] <= 7'h00;
        filt_ff[ch]    <= 1'b0;
      end
      else if (!chan_on[ch] || (raw_sync_ff[1] != raw_prev_ff))
        deb_cnt_ff[ch] <= 7'h00;
      else if (deb_cnt_ff[ch] >= deb_int[ch])
        filt_ff[ch] <= ~raw_sync_ff[1];
      else if (tick)
        deb_cnt_ff[ch] <= deb_cnt_ff[ch] + 7'h01;
    end
  end

  assign alarm_rise = alarm_sync_ff[1] & ~alarm_prev_ff;
  assign lc_rise    = filt_ff[0] & ~filt_prev_ff[0];
  assign rt_rise    = filt_ff[1] & ~filt_prev_ff[1];

  // shadow state: a new software write is taken as is, automatic moves
  // override it without touching the written value; alarm wins over detects
  always_comb
  begin
    nxt_shadow = shadow_ff;
    if (linefeed_state_written_in != written_prev_ff)
      nxt_shadow = linefeed_state_written_in;
    if (lc_rise && auto_man_ff[LSF_BIT_AUTO_LC] && shadow_ff == LSF_LF_REV_OHT)
      nxt_shadow = LSF_LF_REV_ACT;
    if (lc_rise && auto_man_ff[LSF_BIT_AUTO_LC] && shadow_ff == LSF_LF_FWD_OHT)
      nxt_shadow = LSF_LF_FWD_ACT;
    if (rt_rise && auto_man_ff[LSF_BIT_AUTO_RT] && shadow_ff == LSF_LF_RINGING)
      nxt_shadow = LSF_LF_FWD_ACT;
    if (alarm_rise && auto_man_ff[LSF_BIT_AUTO_OPEN])
      nxt_shadow = LSF_LF_OPEN;
  end

  // the shadow starts open and then copies each change of the written state, unless an automatic move overrides it
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      shadow_ff       <= LSF_LF_OPEN;
      written_prev_ff <= LSF_LF_OPEN;
      filt_prev_ff    <= 2'h0;
    end
    else
    begin
      shadow_ff       <= nxt_shadow;
      written_prev_ff <= linefeed_state_written_in;
      filt_prev_ff    <= filt_ff;
    end
  end

  assign fwd_state = (shadow_ff == LSF_LF_FWD_ACT) || (shadow_ff == LSF_LF_FWD_OHT);
  assign rev_state = (shadow_ff == LSF_LF_REV_ACT) || (shadow_ff == LSF_LF_REV_OHT);

  always_comb
  begin
    nxt_batt_tgt = high_battery_setting_in;
    if (auto_man_ff[LSF_BIT_AUTO_BAT] && filt_ff[0] && !batt_feed_ff[LSF_BIT_FORCE_BATTERY_HIGH])
      nxt_batt_tgt = low_battery_setting_in;
  end

  // registered drive to the analogue feed; one cycle behind the registers
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      batt_tgt_ff   <= 6'h00;
      batt_floor_ff <= 6'h00;
      cm_tip_ff     <= 1'b0;
      cm_ring_ff    <= 1'b0;
      low_bat_ff    <= 1'b0;
      ilim_ma_ff    <= LSF_ILIM_BASE_MA;
    end
    else
    begin
      batt_tgt_ff   <= nxt_batt_tgt;
      batt_floor_ff <= batt_feed_ff[LSF_BIT_TRACK] ? 6'h00 : low_battery_setting_in;
      cm_tip_ff     <= auto_man_ff[LSF_BIT_CM_MAN] & fwd_state;
      cm_ring_ff    <= auto_man_ff[LSF_BIT_CM_MAN] & rev_state;
      low_bat_ff    <= auto_man_ff[LSF_BIT_AUTO_BAT] & filt_ff[0] &
                       ~batt_feed_ff[LSF_BIT_FORCE_BATTERY_HIGH];
      ilim_ma_ff    <= LSF_ILIM_BASE_MA + 6'(ilim_ff[2:0] * LSF_ILIM_STEP_MA);
    end
  end

  assign reg_rdata_out             = rdata_ff;
  assign reg_rvalid_out            = rvalid_ff;
  assign linefeed_state_actual_out = shadow_ff;
  assign overhead_range_sel_out    = batt_feed_ff[LSF_BIT_OVR_RANGE];
  assign force_battery_high_out    = batt_feed_ff[LSF_BIT_FORCE_BATTERY_HIGH];
  assign battery_target_out        = batt_tgt_ff;
  assign battery_floor_out         = batt_floor_ff;
  assign battery_track_ring_out    = batt_feed_ff[LSF_BIT_TRACK];
  assign cm_force_tip_out          = cm_tip_ff;
  assign cm_force_ring_out         = cm_ring_ff;
  assign cm_level_out              = common_mode_setting_in;
  assign diff_force_out            = auto_man_ff[LSF_BIT_DIFF_MAN];
  assign diff_level_out            = on_hook_voltage_setting_in;
  assign speedup_enable_out        = auto_man_ff[LSF_BIT_SPEEDUP];
  assign low_battery_select_out    = low_bat_ff;
  assign loop_current_code_out     = ilim_ff[2:0];
  assign loop_current_ma_out       = ilim_ma_ff;
  assign ring_trip_filtered_out    = filt_ff[1];
  assign loop_closure_filtered_out = filt_ff[0];

  property p_force_batt;
    @(posedge clk_in) disable iff (!rstn_in)
    force_battery_high_out |=> battery_target_out == $past(high_battery_setting_in);
  endproperty
  a_force_batt: assert property (p_force_batt)
    else $error("forced battery target does not follow high battery");

  property p_floor;
    @(posedge clk_in) disable iff (!rstn_in)
    !battery_track_ring_out |=> battery_floor_out == $past(low_battery_setting_in);
  endproperty
  a_floor: assert property (p_floor)
    else $error("battery floor is not the low battery setting");

  property p_cm_tip;
    @(posedge clk_in) disable iff (!rstn_in)
    (auto_man_ff[LSF_BIT_CM_MAN] && shadow_ff == LSF_LF_FWD_ACT) |=> cm_force_tip_out
      && !cm_force_ring_out;
  endproperty
  a_cm_tip: assert property (p_cm_tip)
    else $error("manual common mode did not force tip");

  property p_status_read;
    @(posedge clk_in) disable iff (!rstn_in)
    (reg_rd_in && reg_addr_in == LSF_OFS_DET_STATUS) |=>
      reg_rvalid_out && reg_rdata_out[7:3] == 5'h00 && reg_rdata_out[0] == $past(filt_ff[0]);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read shows reserved bits or wrong loop closure");

  property p_filter_wait;
    @(posedge clk_in) disable iff (!rstn_in)
    $rose(filt_ff[0]) |-> $past(deb_cnt_ff[0] >= deb_int[0] && raw_sync_ff[1] == 1'b0);
  endproperty
  a_filter_wait: assert property (p_filter_wait)
    else $error("loop closure reported before the debounce interval");

  property p_alarm_open;
    @(posedge clk_in) disable iff (!rstn_in)
    (alarm_rise && auto_man_ff[LSF_BIT_AUTO_OPEN]) |=> linefeed_state_actual_out == LSF_LF_OPEN;
  endproperty
  a_alarm_open: assert property (p_alarm_open)
    else $error("power alarm did not open the line");

  property p_ring_trip;
    @(posedge clk_in) disable iff (!rstn_in)
    (rt_rise && auto_man_ff[LSF_BIT_AUTO_RT] && shadow_ff == LSF_LF_RINGING && !alarm_rise)
      |=> linefeed_state_actual_out == LSF_LF_FWD_ACT;
  endproperty
  a_ring_trip: assert property (p_ring_trip)
    else $error("ring trip did not move the line to active");

  property p_ilim_ma;
    @(posedge clk_in) disable iff (!rstn_in)
    ##1 (ilim_ff == $past(ilim_ff)) |-> loop_current_ma_out == 6'(20 + 3 * ilim_ff[2:0]);
  endproperty
  a_ilim_ma: assert property (p_ilim_ma)
    else $error("loop current figure does not match the code");

endmodule : lsf_feed_ctrl

//--- tb/lsf_line_model.sv
// lsf_line_model: stand-in for the analogue feed and the subscriber line.
// assumes the bench commands hook state and alarm on the core clock edge.
`timescale 1ns/1ps

module lsf_line_model #(
  parameter int LAG = 2
) (
  input  wire logic clk_in,
  input  wire logic off_hook_in,
  input  wire logic alarm_in,
  output logic      detect_raw_n_out,
  output logic      power_alarm_out
);
  // lag of the loop before the comparator trips; LAG must be 2 or more
  logic [LAG-1:0] hook_ff = '0;
  logic           alarm_ff = 1'b0;

  always @(posedge clk_in)
  begin
    hook_ff  <= {hook_ff[LAG-2:0], off_hook_in};
    alarm_ff <= alarm_in;
  end

  assign detect_raw_n_out = ~hook_ff[LAG-1];
  assign power_alarm_out  = alarm_ff;
endmodule : lsf_line_model

//--- tb/lsf_feed_ctrl_tb.sv
// lsf_feed_ctrl_tb: register, status, debounce and linefeed shadow tests.
// assumes the line model above and a shortened debounce tick.
`timescale 1ns/1ps

module lsf_feed_ctrl_tb;
  import lsf_pkg::*;
  logic       clk_in = 1'b0;
  logic       rstn_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       rvalid;
  logic       off_hook = 1'b0;
  logic       alarm = 1'b0;
  logic       raw_n;
  logic       palarm;
  logic [2:0] lf_wr = LSF_LF_FWD_OHT;
  logic [2:0] lf_act;
  logic [2:0] ilim;
  // high battery kept above low battery, as software must
  logic [5:0] vbh = 6'h32;
  logic [5:0] vbl = 6'h10;
  logic [5:0] common_mode_setting = 6'h02;
  logic [5:0] on_hook_voltage_setting = 6'h20;
  logic [5:0] tgt, flr, cml, dfl, ima;
  logic       ovr, fvb, trk, cmt, cmr, dff, spd, lbs, ring_trip_filtered, loop_closure_filtered;
  logic [7:0] msk [6] = '{8'h19, 8'h7F, 8'h04, 8'h7F, 8'h7F, 8'h07};
  int         miscompares = 0;
  int         check_count = 0;
  int         cycles = 0;

  always #20 clk_in = ~clk_in;

  lsf_line_model line (.clk_in(clk_in), .off_hook_in(off_hook), .alarm_in(alarm),
    .detect_raw_n_out(raw_n), .power_alarm_out(palarm));

  // short tick keeps each debounce step to four cycles
  lsf_feed_ctrl #(.TICK_CYCLES(4)) uut (
    .clk_in(clk_in), .rstn_in(rstn_in), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .detect_raw_n_in(raw_n), .power_alarm_in(palarm), .linefeed_state_written_in(lf_wr),
    .high_battery_setting_in(vbh), .low_battery_setting_in(vbl),
    .common_mode_setting_in(common_mode_setting), .on_hook_voltage_setting_in(on_hook_voltage_setting),
    .linefeed_state_actual_out(lf_act), .overhead_range_sel_out(ovr),
    .force_battery_high_out(fvb), .battery_target_out(tgt), .battery_floor_out(flr),
    .battery_track_ring_out(trk), .cm_force_tip_out(cmt), .cm_force_ring_out(cmr),
    .cm_level_out(cml), .diff_force_out(dff), .diff_level_out(dfl),
    .speedup_enable_out(spd), .low_battery_select_out(lbs), .loop_current_code_out(ilim),
    .loop_current_ma_out(ima), .ring_trip_filtered_out(ring_trip_filtered),
    .loop_closure_filtered_out(loop_closure_filtered));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic chk_bit(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic chk_val(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val

  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : settle

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    int n;
    @(posedge clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    n = 0;
    while (rvalid !== 1'b1 && n < 4)
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk_bit("rvalid", 1'b1, rvalid);
    chk_val("rdata", exp, rdata);
  endtask : rd_chk

  task automatic drive_line(input logic oh, input logic al, input logic [2:0] lf);
    @(posedge clk_in);
    off_hook <= oh;
    alarm    <= al;
    lf_wr    <= lf;
  endtask : drive_line

  // bounded wait on a filtered bit: sel 1 is ring trip, 0 loop closure
  task automatic wait_flt(input logic sel, input logic v);
    int n;
    #1;
    n = 0;
    while (((sel ? ring_trip_filtered : loop_closure_filtered) !== v) && n < 60)
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk_bit(sel ? "ring_trip" : "loop_closure", v, sel ? ring_trip_filtered : loop_closure_filtered);
  endtask : wait_flt

  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      miscompares++;
      wrap_up();
    end
  end

  initial
  begin
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1;
    rd_chk(LSF_OFS_BATT_FEED, LSF_RST_BATT_FEED);
    rd_chk(LSF_OFS_AUTO_MAN, 8'h1F);
    rd_chk(LSF_OFS_DET_STATUS, 8'h04);
    rd_chk(LSF_OFS_LC_DEBOUNCE, 8'h0A);
    rd_chk(LSF_OFS_RT_DEBOUNCE, 8'h0A);
    rd_chk(LSF_OFS_ILIM, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      wr_reg(8'h42 + i[7:0], 8'hFF);
      rd_chk(8'h42 + i[7:0], msk[i]);
    end
    wr_reg(8'h50, 8'hFF);
    rd_chk(8'h50, 8'h00);
    settle(3);
    chk_bit("ovr_range", 1'b1, ovr);
    chk_bit("force_bat", 1'b1, fvb);
    chk_val("bat_target", {2'h0, vbh}, {2'h0, tgt});
    chk_bit("track", 1'b1, trk);
    chk_val("bat_floor", 8'h00, {2'h0, flr});
    chk_bit("diff_force", 1'b1, dff);
    chk_val("diff_level", {2'h0, on_hook_voltage_setting}, {2'h0, dfl});
    chk_val("cm_level", {2'h0, common_mode_setting}, {2'h0, cml});
    chk_bit("speedup", 1'b1, spd);
    wr_reg(LSF_OFS_BATT_FEED, 8'h00);
    wr_reg(LSF_OFS_AUTO_MAN, 8'h40);
    settle(3);
    chk_bit("ovr_range", 1'b0, ovr);
    chk_bit("force_bat", 1'b0, fvb);
    chk_val("bat_floor", {2'h0, vbl}, {2'h0, flr});
    chk_bit("diff_force", 1'b0, dff);
    chk_bit("speedup", 1'b0, spd);
    for (int c = 0; c < 8; c++)
    begin
      wr_reg(LSF_OFS_ILIM, c[7:0]);
      settle(3);
      chk_val("ilim_code", c[7:0], {5'h00, ilim});
      chk_val("ilim_ma", 8'h14 + 8'h03 * c[7:0], {2'h0, ima});
    end
    // common mode manual on, every linefeed code copied to the shadow
    for (int s = 0; s < 8; s++)
    begin
      drive_line(1'b0, 1'b0, s[2:0]);
      settle(4);
      chk_val("shadow", s[7:0], {5'h00, lf_act});
      chk_bit("cm_tip", (s == 1) || (s == 2), cmt);
      chk_bit("cm_ring", (s == 5) || (s == 6), cmr);
    end
    // loop closure, three-step debounce, auto battery only
    wr_reg(LSF_OFS_LC_DEBOUNCE, 8'h03);
    wr_reg(LSF_OFS_AUTO_MAN, 8'h08);
    drive_line(1'b0, 1'b0, LSF_LF_FWD_OHT);
    settle(4);
    drive_line(1'b1, 1'b0, LSF_LF_FWD_OHT);
    settle(10);
    chk_bit("loop_closure_early", 1'b0, loop_closure_filtered);
    wait_flt(1'b0, 1'b1);
    rd_chk(LSF_OFS_DET_STATUS, 8'h01);
    settle(3);
    chk_val("shadow", {5'h00, LSF_LF_FWD_OHT}, {5'h00, lf_act});
    chk_bit("low_bat_sel", 1'b1, lbs);
    chk_val("bat_target", {2'h0, vbl}, {2'h0, tgt});
    drive_line(1'b0, 1'b0, LSF_LF_FWD_OHT);
    drive_line(1'b1, 1'b0, LSF_LF_FWD_OHT);
    settle(5);
    chk_bit("loop_closure_glitch", 1'b1, loop_closure_filtered);
    wr_reg(LSF_OFS_BATT_FEED, 8'h08);
    vbh <= 6'h3C;
    settle(3);
    chk_val("bat_target", 8'h3C, {2'h0, tgt});
    chk_bit("low_bat_sel", 1'b0, lbs);
    wr_reg(LSF_OFS_BATT_FEED, 8'h00);
    // automatic loop closure from reverse on-hook transmission
    drive_line(1'b0, 1'b0, LSF_LF_REV_OHT);
    wait_flt(1'b0, 1'b0);
    wr_reg(LSF_OFS_AUTO_MAN, 8'h02);
    drive_line(1'b1, 1'b0, LSF_LF_REV_OHT);
    wait_flt(1'b0, 1'b1);
    settle(3);
    chk_val("shadow", {5'h00, LSF_LF_REV_ACT}, {5'h00, lf_act});
    drive_line(1'b0, 1'b0, LSF_LF_REV_OHT);
    wait_flt(1'b0, 1'b0);
    // ring trip, manual then automatic, no debounce
    wr_reg(LSF_OFS_RT_DEBOUNCE, 8'h00);
    wr_reg(LSF_OFS_AUTO_MAN, 8'h00);
    drive_line(1'b0, 1'b0, LSF_LF_RINGING);
    settle(4);
    drive_line(1'b1, 1'b0, LSF_LF_RINGING);
    wait_flt(1'b1, 1'b1);
    settle(3);
    chk_val("shadow", {5'h00, LSF_LF_RINGING}, {5'h00, lf_act});
    rd_chk(LSF_OFS_DET_STATUS, 8'h02);
    drive_line(1'b0, 1'b0, LSF_LF_RINGING);
    wait_flt(1'b1, 1'b0);
    wr_reg(LSF_OFS_AUTO_MAN, 8'h04);
    drive_line(1'b1, 1'b0, LSF_LF_RINGING);
    wait_flt(1'b1, 1'b1);
    settle(3);
    chk_val("shadow", {5'h00, LSF_LF_FWD_ACT}, {5'h00, lf_act});
    // power alarm, manual then automatic open
    wr_reg(LSF_OFS_AUTO_MAN, 8'h00);
    drive_line(1'b0, 1'b0, LSF_LF_REV_ACT);
    settle(4);
    drive_line(1'b0, 1'b1, LSF_LF_REV_ACT);
    settle(6);
    chk_val("shadow", {5'h00, LSF_LF_REV_ACT}, {5'h00, lf_act});
    drive_line(1'b0, 1'b0, LSF_LF_REV_ACT);
    wr_reg(LSF_OFS_AUTO_MAN, 8'h01);
    drive_line(1'b0, 1'b1, LSF_LF_REV_ACT);
    settle(6);
    chk_val("shadow", {5'h00, LSF_LF_OPEN}, {5'h00, lf_act});
    wrap_up();
  end
endmodule : lsf_feed_ctrl_tb
